//--- rtl/lbs_code_check.sv
`timescale 1ns/100ps
module lbs_code_check
   import lbs_pkg::*;
(
   input wire logic [VAL_W-1:0] code,
   input wire logic [VAL_W-1:0] arg,
   output logic ok
);
   always_comb begin
      case (code)
         CODE_CARD: ok = (arg >= ARG_MIN) && (arg <= ARG_CARD_MAX);
         CODE_LOADER: ok = (arg >= ARG_MIN) && (arg <= ARG_STD_MAX);
         CODE_LOGIC: ok = (arg >= ARG_MIN) && (arg <= ARG_STD_MAX);
         CODE_HW: ok = (arg >= ARG_MIN) && (arg <= ARG_STD_MAX);
         CODE_RAM: ok = (arg == ARG_RAM);
         default: ok = 1'b0;
      endcase
   end
endmodule // lbs_code_check

//--- rtl/lbs_pkg.sv
package lbs_pkg;
   // clock and flash timing, times in ns, counts derived at 200 MHz
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned FAST_HALF_NS = 100_000_000;
   localparam int unsigned SLOW_HALF_NS = 400_000_000;
   localparam int unsigned PAUSE_NS = 1_000_000_000;
   localparam int unsigned FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned PAUSE_CYC = PAUSE_NS / CLK_PERIOD_NS;
   localparam int unsigned PREAMBLE_FLASHES = 8;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned FLASH_W = 4;
   localparam int unsigned VAL_W = 3;

   // runtime state encoding from the startup firmware
   localparam logic [1:0] RT_STOP = 2'h0;
   localparam logic [1:0] RT_RUN = 2'h1;
   localparam logic [1:0] RT_CONFIG = 2'h2;

   // fault codes and their argument ranges
   localparam logic [2:0] CODE_CARD = 3'h1;
   localparam logic [2:0] CODE_LOADER = 3'h2;
   localparam logic [2:0] CODE_LOGIC = 3'h3;
   localparam logic [2:0] CODE_HW = 3'h4;
   localparam logic [2:0] CODE_RAM = 3'h5;
   localparam logic [2:0] ARG_MIN = 3'h1;
   localparam logic [2:0] ARG_CARD_MAX = 3'h7;
   localparam logic [2:0] ARG_STD_MAX = 3'h6;
   localparam logic [2:0] ARG_RAM = 3'h5;

   typedef enum logic [2:0] {
      S_IDLE,
      S_PRE,
      S_CODE,
      S_PAUSE,
      S_ARG,
      S_GAP
   } lbs_seq_t;
endpackage

//--- rtl/lbs_sequencer.sv
`timescale 1ns/100ps
module lbs_sequencer
   import lbs_pkg::*;
#(
   parameter int unsigned FAST_HALF = FAST_HALF_CYC,
   parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
   parameter int unsigned PAUSE_LEN = PAUSE_CYC,
   parameter int unsigned PRE_FLASHES = PREAMBLE_FLASHES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [1:0] rt_state,
   input wire logic plc_fault,
   input wire logic boot_damaged,
   input wire logic fault_valid,
   input wire logic [VAL_W-1:0] fault_code,
   input wire logic [VAL_W-1:0] fault_arg,
   output logic status_red,
   output logic status_green,
   output logic status_blue,
   output logic err_lamp,
   output logic spare_indicator,
   output logic fault_active,
   output logic fault_rejected
);
   typedef struct packed {
      lbs_seq_t seq;
      logic latched;
      logic rejected;
      logic [VAL_W-1:0] code;
      logic [VAL_W-1:0] arg;
      logic lamp;
      logic [FLASH_W-1:0] flashes;
      logic [CNT_W-1:0] cnt;
      logic err;
      logic red;
      logic green;
      logic blue;
      logic spare;
   } lbs_state_t;

   lbs_state_t st;
   lbs_state_t next_st;
   logic fast_tick;
   logic slow_tick;
   logic restart;
   logic code_ok;
   logic in_burst;
   logic burst_tick;
   logic [FLASH_W-1:0] burst_len;

   lbs_tick_gen #(.HALF(FAST_HALF)) u_fast (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .restart(restart),
      .tick(fast_tick)
   );

   lbs_tick_gen #(.HALF(SLOW_HALF)) u_slow (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .restart(restart),
      .tick(slow_tick)
   );

   lbs_code_check u_check (
      .code(fault_code),
      .arg(fault_arg),
      .ok(code_ok)
   );

   always_comb begin
      in_burst = (st.seq == S_PRE) || (st.seq == S_CODE) || (st.seq == S_ARG);
      burst_tick = (st.seq == S_PRE) ? fast_tick : slow_tick;
      case (st.seq)
         S_PRE: burst_len = FLASH_W'(PRE_FLASHES);
         S_CODE: burst_len = {1'b0, st.code};
         S_ARG: burst_len = {1'b0, st.arg};
         default: burst_len = '0;
      endcase
   end

   always_comb begin
      next_st = st;
      // reserved lamp has no function; held dark in a flop like every other output
      next_st.spare = 1'b0;
      // the bootloader flag is sticky: once seen it owns the panel until reset
      next_st.err = st.err | boot_damaged;
      // first valid code wins; later reports are ignored until reset
      if (fault_valid && !st.latched && code_ok) begin
         next_st.latched = 1'b1;
         next_st.code = fault_code;
         next_st.arg = fault_arg;
      end
      if (fault_valid && !st.latched && !code_ok) begin
         next_st.rejected = 1'b1;
      end

      case (st.seq)
         S_IDLE: begin
            next_st.lamp = 1'b0;
            if (st.latched) begin
               next_st.seq = S_PRE;
            end
         end
         S_PRE, S_CODE, S_ARG: begin
            // each flash is an off half followed by an on half
            if (burst_tick) begin
               if (!st.lamp) begin
                  next_st.lamp = 1'b1;
               end else begin
                  next_st.lamp = 1'b0;
                  if (st.flashes + 1'b1 == burst_len) begin
                     next_st.flashes = '0;
                     next_st.cnt = CNT_W'(PAUSE_LEN - 1);
                     case (st.seq)
                        S_PRE: next_st.seq = S_CODE;
                        S_CODE: next_st.seq = S_PAUSE;
                        default: next_st.seq = S_GAP;
                     endcase
                  end else begin
                     next_st.flashes = st.flashes + 1'b1;
                  end
               end
            end
         end
         S_PAUSE, S_GAP: begin
            next_st.lamp = 1'b0;
            if (st.cnt == '0) begin
               // the gap loops back so the report repeats while latched
               next_st.seq = (st.seq == S_PAUSE) ? S_ARG : S_PRE;
            end else begin
               next_st.cnt = st.cnt - 1'b1;
            end
         end
         default: begin
            next_st.seq = S_IDLE;
            next_st.lamp = 1'b0;
         end
      endcase

      // panel priority: damaged loader, fault report, program crash, run state
      if (next_st.err) begin
         next_st.red = 1'b0;
         next_st.green = 1'b0;
         next_st.blue = 1'b0;
      end else if (next_st.latched) begin
         next_st.red = next_st.lamp;
         next_st.green = 1'b0;
         next_st.blue = 1'b0;
      end else if (plc_fault) begin
         next_st.red = 1'b1;
         next_st.green = 1'b1;
         next_st.blue = 1'b0;
      end else begin
         next_st.red = (rt_state != RT_RUN) && (rt_state != RT_CONFIG);
         next_st.green = (rt_state == RT_RUN);
         next_st.blue = (rt_state == RT_CONFIG);
      end
   end

   // every phase change realigns both tick generators, so each half starts at entry
   assign restart = (next_st.seq != st.seq);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign status_red = st.red;
   assign status_green = st.green;
   assign status_blue = st.blue;
   assign err_lamp = st.err;
   assign spare_indicator = st.spare;
   assign fault_active = st.latched;
   assign fault_rejected = st.rejected;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   logic quiet;
   assign quiet = !boot_damaged && !st.err && !st.latched && !fault_valid;

   a_run_green: assert property (quiet && !plc_fault && rt_state == RT_RUN
      |=> status_green && !status_red && !status_blue)
      else $error("run state not shown green");

   a_stop_red: assert property (quiet && !plc_fault && rt_state == RT_STOP
      |=> status_red && !status_green && !status_blue)
      else $error("stop state not shown red");

   a_config_blue: assert property (quiet && !plc_fault && rt_state == RT_CONFIG
      |=> status_blue && !status_red && !status_green)
      else $error("config state not shown blue");

   a_crash_yellow: assert property (quiet && plc_fault
      |=> status_red && status_green && !status_blue)
      else $error("program fault not shown yellow");

   a_report_red_only: assert property (st.latched && !st.err
      |-> !status_green && !status_blue)
      else $error("fault report used a colour other than red");

   a_fast_preamble: assert property (st.seq == S_PRE && next_st.lamp != st.lamp
      |-> fast_tick)
      else $error("preamble lamp changed off the fast tick");

   a_slow_bursts: assert property ((st.seq == S_CODE || st.seq == S_ARG)
      && next_st.lamp != st.lamp |-> slow_tick)
      else $error("burst lamp changed off the slow tick");

   a_seq_order: assert property (st.seq == S_ARG && $past(st.seq) != S_ARG
      |-> $past(st.seq) == S_PAUSE)
      else $error("argument burst not preceded by pause");

   a_code_entry: assert property (st.seq == S_CODE && $past(st.seq) != S_CODE
      |-> $past(st.seq) == S_PRE)
      else $error("code burst not preceded by preamble");

   a_pause_entry: assert property (st.seq == S_PAUSE && $past(st.seq) != S_PAUSE
      |-> $past(st.seq) == S_CODE)
      else $error("pause not preceded by code burst");

   a_gap_entry: assert property (st.seq == S_GAP && $past(st.seq) != S_GAP
      |-> $past(st.seq) == S_ARG)
      else $error("gap not preceded by argument burst");

   a_pause_dark: assert property (st.seq == S_PAUSE && !st.err
      |-> !status_red)
      else $error("lamp lit during pause");

   a_dark_outside_burst: assert property (!in_burst
      |-> !st.lamp)
      else $error("lamp lit outside a burst");

   a_code_count: assert property ($past(st.seq) == S_CODE && st.seq == S_PAUSE
      |-> $past(st.flashes) + 1'b1 == {1'b0, st.code})
      else $error("code burst flash count wrong");

   a_arg_count: assert property ($past(st.seq) == S_ARG && st.seq == S_GAP
      |-> $past(st.flashes) + 1'b1 == {1'b0, st.arg})
      else $error("argument burst flash count wrong");

   a_bad_refused: assert property (
      fault_valid && !code_ok && !st.latched |=> !st.latched && st.rejected)
      else $error("invalid code or argument was latched");

   a_boot_only_err: assert property (boot_damaged
      |=> err_lamp && !status_red && !status_green && !status_blue)
      else $error("status lamp active with damaged bootloader");

   a_err_sticky: assert property (st.err
      |=> st.err)
      else $error("error lamp cleared before reset");

   a_pre_length: assert property ($past(st.seq) == S_PRE && st.seq == S_CODE
      |-> $past(st.flashes) + 1'b1 == FLASH_W'(PRE_FLASHES))
      else $error("preamble length wrong");

   a_pause_holds: assert property (st.seq == S_PAUSE && st.cnt != '0
      |=> st.seq == S_PAUSE)
      else $error("pause ended before its count ran out");

   a_latch_hold: assert property (st.latched
      |=> st.latched && $stable(st.code) && $stable(st.arg))
      else $error("latched fault changed before reset");

   a_idle_waits: assert property (st.seq == S_IDLE && !st.latched
      |=> st.seq == S_IDLE)
      else $error("report started with nothing latched");

   a_pre_entry: assert property (st.seq == S_PRE && $past(st.seq) != S_PRE
      |-> $past(st.seq) == S_GAP || $past(st.seq) == S_IDLE)
      else $error("preamble entered from a wrong phase");

   a_gap_holds: assert property (st.seq == S_GAP && st.cnt != '0
      |=> st.seq == S_GAP)
      else $error("gap ended before its count ran out");

   a_repeat: assert property (st.seq == S_GAP && st.cnt == '0
      |=> st.seq == S_PRE)
      else $error("report did not repeat");

   c_code_burst: cover property (st.seq == S_PRE ##1 st.seq == S_CODE);
   c_arg_burst: cover property (st.seq == S_PAUSE ##1 st.seq == S_ARG);
   c_repeat: cover property (st.seq == S_GAP ##1 st.seq == S_PRE);
   c_yellow: cover property (status_red && status_green);
   c_boot: cover property (err_lamp);
endmodule // lbs_sequencer

//--- rtl/lbs_tick_gen.sv
`timescale 1ns/100ps
module lbs_tick_gen
   import lbs_pkg::*;
#(
   parameter int unsigned HALF = 2
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic restart,
   output logic tick
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } lbs_tick_st_t;

   lbs_tick_st_t st;
   lbs_tick_st_t next_st;

   // restart realigns the half period to the start of a new phase
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (restart) begin
         next_st.cnt = '0;
      end else if (st.cnt == CNT_W'(HALF - 1)) begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

   a_tick_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
      st.tick |=> !st.tick)
      else $error("tick lasted more than one cycle");
endmodule // lbs_tick_gen

//--- verification/lbs_fw_model.sv
`timescale 1ns/100ps
module lbs_fw_model
   import lbs_pkg::*;
(
   input wire logic core_clk,
   output logic [1:0] rt_state,
   output logic plc_fault,
   output logic boot_damaged,
   output logic fault_valid,
   output logic [VAL_W-1:0] fault_code,
   output logic [VAL_W-1:0] fault_arg
);
   initial begin
      rt_state = RT_STOP;
      plc_fault = 1'b0;
      boot_damaged = 1'b0;
      fault_valid = 1'b0;
      fault_code = 3'h0;
      fault_arg = 3'h0;
   end
   task automatic set_status(input logic [1:0] st, input logic pf, input logic bd);
      @(posedge core_clk);
      rt_state <= st;
      plc_fault <= pf;
      boot_damaged <= bd;
   endtask
   task automatic send_fault(input logic [VAL_W-1:0] c, input logic [VAL_W-1:0] a);
      @(posedge core_clk);
      fault_valid <= 1'b1;
      fault_code <= c;
      fault_arg <= a;
      @(posedge core_clk);
      // junk outside the strobe, so a late sample latches a wrong pair
      fault_valid <= 1'b0;
      fault_code <= ~c;
      fault_arg <= ~a;
   endtask
endmodule // lbs_fw_model

//--- verification/lbs_sequencer_tb.sv
`timescale 1ns/100ps
module lbs_sequencer_tb;
   import lbs_pkg::*;
   localparam int FH = 2;
   localparam int SH = 4;
   localparam int PL = 6;
   localparam int PF = 3;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] rt_state;
   logic plc_fault, boot_damaged, fault_valid;
   logic [VAL_W-1:0] fault_code, fault_arg;
   logic status_red, status_green, status_blue, err_lamp, spare_indicator;
   logic fault_active, fault_rejected;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   int seed = 32'h95cf;
   int lit, dark, grp_n, obs_q[$], exp_q[$];
   bit grp_long, mon_on = 0;
   logic [2:0] pairs_ok[7][2] = '{'{1, 1}, '{1, 7}, '{2, 6}, '{3, 1}, '{4, 6}, '{5, 5}, '{0, 0}};
   logic [2:0] pairs_bad[6][2] = '{'{1, 0}, '{2, 7}, '{5, 4}, '{0, 1}, '{6, 1}, '{3, 7}};

   initial forever #2.5 core_clk = ~core_clk;

   lbs_fw_model fw (.core_clk(core_clk), .rt_state(rt_state), .plc_fault(plc_fault),
      .boot_damaged(boot_damaged), .fault_valid(fault_valid), .fault_code(fault_code),
      .fault_arg(fault_arg));
   lbs_sequencer #(.FAST_HALF(FH), .SLOW_HALF(SH), .PAUSE_LEN(PL), .PRE_FLASHES(PF)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .rt_state(rt_state), .plc_fault(plc_fault),
      .boot_damaged(boot_damaged), .fault_valid(fault_valid), .fault_code(fault_code),
      .fault_arg(fault_arg), .status_red(status_red), .status_green(status_green),
      .status_blue(status_blue), .err_lamp(err_lamp), .spare_indicator(spare_indicator),
      .fault_active(fault_active), .fault_rejected(fault_rejected));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
   endtask
   function automatic logic [2:0] colour(input logic [1:0] st, input logic pf);
      if (pf) return 3'h6;
      if (st == RT_RUN) return 3'h2;
      if (st == RT_CONFIG) return 3'h1;
      return 3'h4;
   endfunction

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         report_and_stop();
      end
   end
   // groups flashes by lit length and by long dark gaps
   always @(posedge core_clk) begin
      if (!mon_on) begin
         lit = 0;
         dark = 0;
         grp_n = 0;
      end else begin
         chk("report_green_blue", {status_green, status_blue}, 2'h0);
         chk("spare", spare_indicator, 1'b0);
         if (status_red === 1'b1) lit++;
         else begin
            if (lit > 0) begin
               if (grp_n > 0 && (dark > SH + 2 || (lit > (FH + SH) / 2) != grp_long)) begin
                  obs_q.push_back(grp_n + (grp_long ? 16 : 0));
                  grp_n = 0;
               end
               grp_long = lit > (FH + SH) / 2;
               grp_n++;
               lit = 0;
               dark = 0;
            end
            dark++;
         end
      end
   end

   initial begin
      logic [2:0] c, a;
      do_reset();
      for (int i = 0; i < 12; i++) begin
         c = (i < 8) ? colour(i[2:1], i[0]) : 3'h0;
         if (i < 8) fw.set_status(i[2:1], i[0], 1'b0);
         else fw.set_status($random(seed), $random(seed), 1'b0);
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         c = colour(rt_state, plc_fault);
         chk("colour", {status_red, status_green, status_blue}, c);
      end
      for (int i = 0; i < 7; i++) begin
         c = (i < 6) ? pairs_ok[i][0] : 3'(1 + {$random(seed)} % 4);
         a = (i < 6) ? pairs_ok[i][1] : 3'(1 + {$random(seed)} % 6);
         do_reset();
         fw.set_status(RT_RUN, 1'b0, 1'b0);
         fw.send_fault(c, a);
         repeat (2) @(posedge core_clk);
         chk("active", {fault_active, fault_rejected}, 2'h2);
         mon_on = 1;
         repeat (5) @(posedge core_clk);
         fw.send_fault(3'h5, 3'h5); // ignored while latched
         exp_q = '{PF, c + 16, a + 16, PF, c + 16, a + 16};
         for (int k = 0; k < 800 && obs_q.size() < 6; k++) @(posedge core_clk);
         chk("groups", obs_q.size(), 6);
         for (int k = 0; k < 6 && k < obs_q.size(); k++)
            chk("burst", obs_q[k], exp_q[k]);
         mon_on = 0;
         obs_q.delete();
      end
      foreach (pairs_bad[i]) begin
         do_reset();
         fw.set_status(RT_RUN, 1'b0, 1'b0);
         fw.send_fault(pairs_bad[i][0], pairs_bad[i][1]);
         repeat (3) @(posedge core_clk);
         chk("reject", {fault_rejected, fault_active, status_green}, 3'h5);
      end
      do_reset();
      fw.send_fault(3'h2, 3'h3);
      repeat (3) @(posedge core_clk);
      chk("err_lamp_off", err_lamp, 1'b0);
      fw.set_status(RT_RUN, 1'b1, 1'b1);
      repeat (3) @(posedge core_clk);
      for (int k = 0; k < 60; k++) begin
         @(negedge core_clk);
         chk("boot_lamps", {err_lamp, status_red, status_green, status_blue}, 4'h8);
      end
      report_and_stop();
   end
endmodule // lbs_sequencer_tb
